// ### logic/eeprom_pkg.sv
package eeprom_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned PROG_TIME_MS    = 5;
	localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned PROG_W          = 19;
	localparam int unsigned QTR_CYCLES      = 25;
	localparam int unsigned QTR_W           = 5;

	// ------------------------------------------------------------
	// Memory organisation
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W    = 17;
	localparam int unsigned MEM_BYTES = 131072;
	localparam logic [3:0]  FAMILY    = 4'ha;

	// ------------------------------------------------------------
	// Controller registers
	// ------------------------------------------------------------
	localparam logic [3:0]  REG_CMD       = 4'h0;
	localparam logic [3:0]  REG_STATUS    = 4'h4;
	localparam int unsigned CMD_START_BIT = 8;
	localparam int unsigned CMD_STOP_BIT  = 9;
	localparam int unsigned CMD_READ_BIT  = 10;
	localparam int unsigned CMD_NACK_BIT  = 11;
	localparam int unsigned CMD_RECOV_BIT = 12;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_ACK_BIT  = 1;
	localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_DEV, S_HI, S_LO, S_WR, S_ACK, S_RD, S_RACK} dev_state_t;
	typedef enum logic [1:0] {C_IDLE, C_START, C_BIT, C_STOP} ctl_state_t;

endpackage : eeprom_pkg

// ### logic/eeprom_bus_if.sv
`timescale 1ns/1ps
interface eeprom_bus_if;
	logic scl_ctl_o;
	logic scl_ctl_oe;
	logic sda_ctl_o;
	logic sda_ctl_oe;
	logic sda_tgt_o;
	logic sda_tgt_oe;
	logic scl;
	logic sda;

	// Open-drain wires with pull-up: released when enable high
	assign scl = scl_ctl_oe | scl_ctl_o;
	assign sda = (sda_ctl_oe | sda_ctl_o) & (sda_tgt_oe | sda_tgt_o);

	modport target (input scl, input sda, output sda_tgt_o, output sda_tgt_oe);
	modport ctrl   (input scl, input sda, output scl_ctl_o, output scl_ctl_oe,
	                output sda_ctl_o, output sda_ctl_oe);
endinterface : eeprom_bus_if

// ### logic/eeprom_target.sv
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module eeprom_target #(
	parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        SRST,
	// Two-wire bus
	eeprom_bus_if.target     BUS,
	// Strap and protect pins
	input  wire logic        DEVICE_SELECT_STRAP_LOW,
	input  wire logic        DEVICE_SELECT_STRAP_HIGH,
	input  wire logic        WRITE_PROTECT
);
	import eeprom_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic               scl_m;
		logic               scl_s;
		logic               scl_p;
		logic               sda_m;
		logic               sda_s;
		logic               sda_p;
		logic [1:0]         strap_m;
		logic [1:0]         strap_s;
		logic               wp_m;
		logic               wp_s;
		dev_state_t         st;
		dev_state_t         nxt;
		logic [3:0]         bits;
		logic [7:0]         shr;
		logic [ADDR_W-1:0]  addr;
		logic               mack;
		logic               wrote;
		logic [PROG_W-1:0]  busy;
		logic               sda_o;
		logic               sda_oe;
	} dev_regs_t;

	localparam dev_regs_t REGS_RESET = '{
		scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
		sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
		strap_m: 2'b00, strap_s: 2'b00, wp_m: 1'b0, wp_s: 1'b0,
		st: S_IDLE, nxt: S_IDLE, bits: 4'h0, shr: 8'h00,
		addr: '0, mack: 1'b0, wrote: 1'b0, busy: '0,
		sda_o: 1'b0, sda_oe: 1'b1
	};

	dev_regs_t          r_q;
	dev_regs_t          r_d;
	logic [7:0]         mem [0:MEM_BYTES-1];
	logic [7:0]         rd_byte;
	logic               mem_we;
	logic               rise;
	logic               fall;
	logic               start;
	logic               stop;
	logic               load_byte;

	// ------------------------------------------------------------
	// Array, 512 pages of 256 bytes
	// ------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (mem_we)
		begin
			mem[r_q.addr] <= r_q.shr;
		end
	end

	assign rd_byte = mem[r_q.addr];

	// ------------------------------------------------------------
	// Bus events
	// ------------------------------------------------------------
	assign rise  = r_q.scl_s & ~r_q.scl_p;
	assign fall  = ~r_q.scl_s & r_q.scl_p;
	assign start = r_q.scl_s & r_q.scl_p & r_q.sda_p & ~r_q.sda_s;
	assign stop  = r_q.scl_s & r_q.scl_p & ~r_q.sda_p & r_q.sda_s;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		r_d       = r_q;
		mem_we    = 1'b0;
		load_byte = 1'b0;

		r_d.scl_m   = BUS.scl;
		r_d.scl_s   = r_q.scl_m;
		r_d.scl_p   = r_q.scl_s;
		r_d.sda_m   = BUS.sda;
		r_d.sda_s   = r_q.sda_m;
		r_d.sda_p   = r_q.sda_s;
		r_d.strap_m = {DEVICE_SELECT_STRAP_HIGH, DEVICE_SELECT_STRAP_LOW};
		r_d.strap_s = r_q.strap_m;
		r_d.wp_m    = WRITE_PROTECT;
		r_d.wp_s    = r_q.wp_m;

		if (r_q.busy != '0)
		begin
			r_d.busy = r_q.busy - 1'b1;
		end

		if (start)
		begin
			// Any state, also mid-byte: recovery sequence lands here
			r_d.sda_oe = 1'b1;
			r_d.bits   = 4'h0;
			r_d.st     = (r_q.busy == '0) ? S_DEV : S_IDLE;
		end
		else if (stop)
		begin
			r_d.sda_oe = 1'b1;
			r_d.st     = S_IDLE;
			if (r_q.wrote)
			begin
				r_d.busy  = PROG_W'(PROG_CYCLES);
				r_d.wrote = 1'b0;
			end
		end
		else
		begin
			case (r_q.st)
				S_DEV, S_HI, S_LO, S_WR:
				begin
					if (rise && r_q.bits != 4'h8)
					begin
						r_d.shr  = {r_q.shr[6:0], r_q.sda_s};
						r_d.bits = r_q.bits + 4'h1;
					end
					else if (fall && r_q.bits == 4'h8)
					begin
						r_d.bits   = 4'h0;
						r_d.st     = S_ACK;
						r_d.sda_oe = 1'b0;
						case (r_q.st)
							S_DEV:
							begin
								if (r_q.shr[7:4] == FAMILY && r_q.shr[3:2] == r_q.strap_s)
								begin
									r_d.nxt = r_q.shr[0] ? S_RD : S_HI;
									if (!r_q.shr[0])
									begin
										r_d.addr[ADDR_W-1] = r_q.shr[1];
									end
								end
								else
								begin
									r_d.sda_oe = 1'b1;
									r_d.st     = S_IDLE;
								end
							end
							S_HI:
							begin
								r_d.addr[15:8] = r_q.shr;
								r_d.nxt        = S_LO;
							end
							S_LO:
							begin
								r_d.addr[7:0] = r_q.shr;
								r_d.nxt       = S_WR;
							end
							default:
							begin
								if (!r_q.wp_s)
								begin
									mem_we    = 1'b1;
									r_d.wrote = 1'b1;
								end
								r_d.addr[7:0] = r_q.addr[7:0] + 8'h01;
								r_d.nxt       = S_WR;
							end
						endcase
					end
				end
				S_ACK:
				begin
					if (fall)
					begin
						r_d.sda_oe = 1'b1;
						if (r_q.nxt == S_RD)
						begin
							load_byte = 1'b1;
						end
						else
						begin
							r_d.st = r_q.nxt;
						end
					end
				end
				S_RD:
				begin
					if (fall)
					begin
						if (r_q.bits == 4'h8)
						begin
							r_d.sda_oe = 1'b1;
							r_d.st     = S_RACK;
						end
						else
						begin
							r_d.sda_oe = r_q.shr[7];
							r_d.shr    = {r_q.shr[6:0], 1'b0};
							r_d.bits   = r_q.bits + 4'h1;
						end
					end
				end
				S_RACK:
				begin
					if (rise)
					begin
						r_d.mack = ~r_q.sda_s;
					end
					else if (fall)
					begin
						if (r_q.mack)
						begin
							load_byte = 1'b1;
						end
						else
						begin
							r_d.st = S_IDLE;
						end
					end
				end
				default:
				begin
					r_d.sda_oe = 1'b1;
				end
			endcase
		end

		if (load_byte)
		begin
			// Counter wraps over the whole array on reads
			r_d.shr    = {rd_byte[6:0], 1'b0};
			r_d.sda_oe = rd_byte[7];
			r_d.bits   = 4'h1;
			r_d.addr   = r_q.addr + 1'b1;
			r_d.st     = S_RD;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			r_q <= REGS_RESET;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	assign BUS.sda_tgt_o  = r_q.sda_o;
	assign BUS.sda_tgt_oe = r_q.sda_oe;

endmodule : eeprom_target

// ### logic/eeprom_controller.sv
`timescale 1ns/1ps
module eeprom_controller (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        SRST,
	// Avalon-MM slave
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// Two-wire bus
	eeprom_bus_if.ctrl       BUS
);
	import eeprom_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic               sda_m;
		logic               sda_s;
		ctl_state_t         st;
		logic [QTR_W-1:0]   div;
		logic [1:0]         qtr;
		logic [3:0]         bitn;
		logic [7:0]         tx;
		logic [7:0]         rx;
		logic               rd;
		logic               nack;
		logic               stop;
		logic               recov;
		logic               again;
		logic               ack;
		logic               scl_oe;
		logic               sda_oe;
		logic               wait_q;
		logic [31:0]        rdata;
	} ctl_regs_t;

	localparam ctl_regs_t REGS_RESET = '{
		sda_m: 1'b1, sda_s: 1'b1, st: C_IDLE, div: '0, qtr: 2'h0, bitn: 4'h0,
		tx: 8'h00, rx: 8'h00, rd: 1'b0, nack: 1'b0, stop: 1'b0, recov: 1'b0,
		again: 1'b0, ack: 1'b0, scl_oe: 1'b1, sda_oe: 1'b1, wait_q: 1'b1,
		rdata: RDATA_RESET
	};

	ctl_regs_t r_q;
	ctl_regs_t r_d;
	logic      tick;

	assign tick = (r_q.div == QTR_W'(QTR_CYCLES - 1));

	always_comb
	begin
		r_d       = r_q;
		r_d.sda_m = BUS.sda;
		r_d.sda_s = r_q.sda_m;

		// --------------------------------------------------------
		// Register access, one answer per request
		// --------------------------------------------------------
		if (!r_q.wait_q)
		begin
			r_d.wait_q = 1'b1;
		end
		else if (AVS_READ)
		begin
			r_d.wait_q = 1'b0;
			r_d.rdata  = RDATA_RESET;
			if (AVS_ADDRESS == REG_STATUS)
			begin
				r_d.rdata[15:8]          = r_q.rx;
				r_d.rdata[STAT_ACK_BIT]  = r_q.ack;
				r_d.rdata[STAT_BUSY_BIT] = (r_q.st != C_IDLE);
			end
		end
		else if (AVS_WRITE && r_q.st == C_IDLE)
		begin
			r_d.wait_q = 1'b0;
			if (AVS_ADDRESS == REG_CMD && AVS_BYTEENABLE[1:0] == 2'b11)
			begin
				r_d.tx    = AVS_WRITEDATA[7:0];
				r_d.rd    = AVS_WRITEDATA[CMD_READ_BIT];
				r_d.nack  = AVS_WRITEDATA[CMD_NACK_BIT];
				r_d.stop  = AVS_WRITEDATA[CMD_STOP_BIT];
				r_d.recov = AVS_WRITEDATA[CMD_RECOV_BIT];
				r_d.again = 1'b0;
				r_d.qtr   = 2'h0;
				r_d.bitn  = 4'h0;
				r_d.div   = '0;
				r_d.st    = (AVS_WRITEDATA[CMD_START_BIT] | AVS_WRITEDATA[CMD_RECOV_BIT])
				            ? C_START : C_BIT;
			end
		end

		// --------------------------------------------------------
		// Bit engine, four quarters per clock period
		// --------------------------------------------------------
		if (r_q.st != C_IDLE)
		begin
			r_d.div = tick ? '0 : r_q.div + 1'b1;
			if (tick)
			begin
				r_d.qtr = r_q.qtr + 2'h1;
				case (r_q.st)
					C_START:
					begin
						case (r_q.qtr)
							2'h0: r_d.sda_oe = 1'b1;
							2'h1: r_d.scl_oe = 1'b1;
							2'h2: r_d.sda_oe = 1'b0;
							default:
							begin
								r_d.scl_oe = 1'b0;
								r_d.st     = r_q.again ? C_STOP : C_BIT;
							end
						endcase
					end
					C_BIT:
					begin
						case (r_q.qtr)
							2'h0:
							begin
								if (r_q.bitn != 4'h8)
								begin
									r_d.sda_oe = (r_q.rd | r_q.recov) ? 1'b1 : r_q.tx[7];
								end
								else
								begin
									r_d.sda_oe = r_q.rd ? r_q.nack : 1'b1;
								end
							end
							2'h1: r_d.scl_oe = 1'b1;
							2'h2:
							begin
								if (r_q.bitn != 4'h8)
								begin
									r_d.rx = {r_q.rx[6:0], r_q.sda_s};
								end
								else
								begin
									r_d.ack = ~r_q.sda_s;
								end
							end
							default:
							begin
								r_d.scl_oe = 1'b0;
								r_d.tx     = {r_q.tx[6:0], 1'b0};
								r_d.bitn   = r_q.bitn + 4'h1;
								if (r_q.bitn == 4'h8)
								begin
									r_d.bitn = 4'h0;
									if (r_q.recov)
									begin
										r_d.recov = 1'b0;
										r_d.again = 1'b1;
										r_d.st    = C_START;
									end
									else
									begin
										r_d.st = r_q.stop ? C_STOP : C_IDLE;
									end
								end
							end
						endcase
					end
					C_STOP:
					begin
						case (r_q.qtr)
							2'h0: r_d.sda_oe = 1'b0;
							2'h1: r_d.scl_oe = 1'b1;
							2'h2: r_d.sda_oe = 1'b1;
							default:
							begin
								r_d.again = 1'b0;
								r_d.st    = C_IDLE;
							end
						endcase
					end
					default: r_d.st = C_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			r_q <= REGS_RESET;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	assign AVS_READDATA    = r_q.rdata;
	assign AVS_WAITREQUEST = r_q.wait_q;
	assign BUS.scl_ctl_o   = 1'b0;
	assign BUS.scl_ctl_oe  = r_q.scl_oe;
	assign BUS.sda_ctl_o   = 1'b0;
	assign BUS.sda_ctl_oe  = r_q.sda_oe;

endmodule : eeprom_controller

// ### verification/eeprom_bus_assertions.sv
`timescale 1ns/1ps
module eeprom_bus_assertions (
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// Bus wires
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_tgt_o,
	input wire logic sda_tgt_oe
);
	// --------
	// Bit tracker
	// --------
	logic [3:0] bit_q;
	logic [3:0] low_q;
	logic [7:0] sh_q;
	logic       scl_q;
	logic       sda_q;
	logic       first_q;
	logic       rd_q;
	logic       idle_q;

	always_ff @(posedge CLK)
	begin
		scl_q <= scl;
		sda_q <= sda;
		if (SRST)
		begin
			bit_q   <= 4'h0;
			low_q   <= 4'h0;
			sh_q    <= 8'h00;
			first_q <= 1'b1;
			rd_q    <= 1'b0;
			idle_q  <= 1'b1;
		end
		else
		begin
			low_q <= scl ? 4'h0 : ((low_q == 4'hf) ? low_q : low_q + 4'h1);
			if (scl && scl_q && sda_q && !sda)
			begin
				bit_q   <= 4'h0;
				first_q <= 1'b1;
				idle_q  <= 1'b0;
			end
			else if (scl && scl_q && !sda_q && sda)
				idle_q <= 1'b1;
			else if (scl && !scl_q)
			begin
				bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
				sh_q  <= {sh_q[6:0], sda};
				if (bit_q == 4'h8 && first_q)
				begin
					first_q <= 1'b0;
					rd_q    <= sh_q[0];
				end
			end
		end
	end

	// --------
	// Checks
	// --------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	a_reset_release: assert property ($fell(SRST) |-> sda_tgt_oe)
		else $error("target holds data line after reset");
	a_drive_zero: assert property (!sda_tgt_oe |-> !sda_tgt_o)
		else $error("target drives a one");
	a_change_scl_low: assert property ($changed(sda_tgt_oe) |-> !scl && low_q inside {[1:8]})
		else $error("target data change outside early clock low");
	a_hold_high: assert property ($rose(scl) && !sda_tgt_oe |-> (!sda_tgt_oe) [*8])
		else $error("target bit not held over clock high");
	a_ack_slot: assert property ($rose(scl) && !sda_tgt_oe && (first_q || !rd_q) |-> bit_q == 4'h8)
		else $error("target low outside ninth clock");
	a_read_release: assert property ($rose(scl) && rd_q && !first_q && bit_q == 4'h8 |-> sda_tgt_oe)
		else $error("target holds line in read ack slot");
	a_idle_quiet: assert property (idle_q |-> sda_tgt_oe)
		else $error("target drives after stop");
	a_start_hold: assert property (scl && $fell(sda) |-> scl [*8])
		else $error("start not held");
	a_stop_hold: assert property (scl && $rose(sda) |-> sda [*8])
		else $error("stop not held");
endmodule : eeprom_bus_assertions

// ### verification/two_wire_eeprom_slave_tb.sv
`timescale 1ns/1ps
module two_wire_eeprom_slave_tb;
	import eeprom_pkg::*;

	localparam int unsigned PROG = 5000;
	localparam logic [4:0]  F_ST = 5'h01;
	localparam logic [4:0]  F_SP = 5'h02;
	localparam logic [4:0]  F_RD = 5'h04;
	localparam logic [4:0]  F_NK = 5'h08;
	localparam logic [4:0]  F_RC = 5'h10;

	logic        clk;
	logic        srst;
	logic        strap_lo;
	logic        strap_hi;
	logic        wp;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [31:0] s;
	logic [7:0]  rx;
	logic        ack;
	int          polls;
	int          n_mismatch;
	int          comparisons;

	eeprom_bus_if eeprom_bus_if_i ();

	eeprom_target #(.PROG_CYCLES(PROG)) eeprom_target_i (
		.CLK                      (clk),
		.SRST                     (srst),
		.BUS                      (eeprom_bus_if_i.target),
		.DEVICE_SELECT_STRAP_LOW  (strap_lo),
		.DEVICE_SELECT_STRAP_HIGH (strap_hi),
		.WRITE_PROTECT            (wp)
	);

	eeprom_controller eeprom_controller_i (
		.CLK             (clk),
		.SRST            (srst),
		.AVS_ADDRESS     (avs_address),
		.AVS_READ        (avs_read),
		.AVS_WRITE       (avs_write),
		.AVS_WRITEDATA   (avs_writedata),
		.AVS_BYTEENABLE  (4'hf),
		.AVS_READDATA    (avs_readdata),
		.AVS_WAITREQUEST (avs_waitrequest),
		.BUS             (eeprom_bus_if_i.ctrl)
	);

	eeprom_bus_assertions eeprom_bus_assertions_i (
		.CLK        (clk),
		.SRST       (srst),
		.scl        (eeprom_bus_if_i.scl),
		.sda        (eeprom_bus_if_i.sda),
		.sda_tgt_o  (eeprom_bus_if_i.sda_tgt_o),
		.sda_tgt_oe (eeprom_bus_if_i.sda_tgt_oe)
	);

	// --------
	// Tasks
	// --------
	task automatic report_and_stop();
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		do
		begin
			@(posedge clk);
		end
		while (avs_waitrequest !== 1'b0);
		s = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge clk);
	endtask : av

	task automatic op(input logic [7:0] d, input logic [4:0] f, output logic [7:0] rb,
		output logic ak);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[7:0] = d;
		w[CMD_START_BIT] = f[0];
		w[CMD_STOP_BIT] = f[1];
		w[CMD_READ_BIT] = f[2];
		w[CMD_NACK_BIT] = f[3];
		w[CMD_RECOV_BIT] = f[4];
		av(1'b1, REG_CMD, w);
		do
		begin
			av(1'b0, REG_STATUS, 32'h0000_0000);
		end
		while (s[STAT_BUSY_BIT] !== 1'b0);
		rb = s[15:8];
		ak = s[STAT_ACK_BIT];
	endtask : op

	function automatic logic [7:0] dev(input logic p, input logic rw);
		return {FAMILY, strap_hi, strap_lo, p, rw};
	endfunction : dev

	task automatic seek(input logic [16:0] a);
		polls = 0;
		do
		begin
			op(dev(a[16], 1'b0), F_ST, rx, ack);
			polls++;
		end
		while (ack !== 1'b1 && polls < 12);
		op(a[15:8], 5'h00, rx, ack);
		chk({7'h00, ack}, 8'h01);
		op(a[7:0], 5'h00, rx, ack);
		chk({7'h00, ack}, 8'h01);
	endtask : seek

	task automatic wr(input logic [16:0] a, input logic [7:0] d [$]);
		seek(a);
		foreach (d[i])
		begin
			op(d[i], (i == d.size() - 1) ? F_SP : 5'h00, rx, ack);
			chk({7'h00, ack}, 8'h01);
		end
	endtask : wr

	task automatic rdseq(input logic [16:0] a, input logic [7:0] e [$]);
		seek(a);
		op(dev(a[16], 1'b1), F_ST, rx, ack);
		chk({7'h00, ack}, 8'h01);
		foreach (e[i])
		begin
			op(8'h00, (i == e.size() - 1) ? (F_RD | F_NK | F_SP) : F_RD, rx, ack);
			chk(rx, e[i]);
		end
	endtask : rdseq

	// --------
	// Sequence
	// --------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		#1_000_000;
		n_mismatch++;
		report_and_stop();
	end

	initial
	begin
		srst = 1'b1;
		strap_lo = 1'b0;
		strap_hi = 1'b0;
		wp = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		n_mismatch = 0;
		comparisons = 0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		av(1'b0, 4'h8, 32'h0000_0000);
		chk(s[7:0], 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			strap_lo <= i[0];
			strap_hi <= i[1];
			repeat (4) @(posedge clk);
			op(dev(1'b0, 1'b0), F_ST | F_SP, rx, ack);
			chk({7'h00, ack}, 8'h01);
			op(dev(1'b0, 1'b0) ^ 8'h0c, F_ST | F_SP, rx, ack);
			chk({7'h00, ack}, 8'h00);
		end
		op(dev(1'b0, 1'b0) ^ 8'h10, F_ST | F_SP, rx, ack);
		chk({7'h00, ack}, 8'h00);
		wr(17'h1_02fe, '{8'h11, 8'h22, 8'h33});
		rdseq(17'h1_02fe, '{8'h11});
		chk({7'h00, polls > 1}, 8'h01);
		chk({7'h00, polls < 12}, 8'h01);
		op(dev(1'b0, 1'b1), F_ST, rx, ack);
		chk({7'h00, ack}, 8'h01);
		op(8'h00, F_RD | F_NK | F_SP, rx, ack);
		chk(rx, 8'h22);
		rdseq(17'h1_0200, '{8'h33});
		wr(17'h1_ffff, '{8'h5a});
		wr(17'h0_0000, '{8'ha5});
		rdseq(17'h1_ffff, '{8'h5a, 8'ha5});
		wp <= 1'b1;
		wr(17'h0_0000, '{8'h3c});
		wp <= 1'b0;
		rdseq(17'h0_0000, '{8'ha5});
		chk(polls[7:0], 8'h01);
		// Cut a read while the target drives a zero
		seek(17'h1_ffff);
		op(dev(1'b1, 1'b1), F_ST, rx, ack);
		chk({7'h00, ack}, 8'h01);
		op(8'h00, F_RC, rx, ack);
		op(dev(1'b0, 1'b0), F_ST | F_SP, rx, ack);
		chk({7'h00, ack}, 8'h01);
		report_and_stop();
	end
endmodule : two_wire_eeprom_slave_tb
